// ===== rtl/eswp_core.sv
// Status register and write-protect logic of a serial nonvolatile memory
`timescale 1ns/1ns
module eswp_core
	import eswp_pkg::*;
#(
	parameter int WRITE_TIME_US = eswp_pkg::WRITE_TIME_US_DEF
) (
	// System
	input wire logic sys_clk,
	input wire logic srst,
	// Serial link
	input wire logic spi_sck,
	input wire logic spi_cs_n,
	input wire logic spi_si,
	output logic spi_so,
	output logic spi_so_oe,
	// Write-protect pin
	input wire logic wp_n,
	// Nonvolatile store
	input wire logic [2:0] nv_restore,
	output logic [2:0] nv_store,
	output logic nv_commit,
	// Array side
	output logic array_wr_go,
	output logic [12:0] array_wr_addr,
	output logic array_access_ok,
	// Status view
	output logic [7:0] status_view
);
	import eswp_pkg::*;

	localparam int WRITE_CYCLES = WRITE_TIME_US * SYS_CLK_MHZ;

	generate
		if (WRITE_TIME_US < 1) begin : g_bad_time
			$error("write time must be at least one microsecond");
		end
	endgenerate

	// Link domain: frame capture on rising clock
	logic lk_started_q;
	logic [7:0] lk_sh_q;
	logic [2:0] lk_bit_q;
	logic [5:0] lk_byte_q;
	logic [7:0] lk_op_q;
	logic [15:0] lk_addr_q;
	logic [7:0] lk_dat_q;
	logic [7:0] lk_sh_d;
	logic [2:0] lk_bit_d;
	logic [5:0] lk_byte_d;
	logic [7:0] lk_op_d;
	logic [15:0] lk_addr_d;
	logic [7:0] lk_dat_d;
	logic [5:0] lk_byte_base;
	logic [7:0] lk_stat;

	always_comb begin
		lk_sh_d = {lk_sh_q[6:0], spi_si};
		lk_bit_d = lk_started_q ? lk_bit_q + BIT_FIRST : BIT_FIRST;
		lk_byte_base = lk_started_q ? lk_byte_q : BYTES_ZERO;
		lk_byte_d = lk_byte_base;
		lk_op_d = lk_op_q;
		lk_addr_d = lk_addr_q;
		lk_dat_d = lk_dat_q;
		if (lk_bit_d == BIT_BOUNDARY) begin
			if (lk_byte_base != BYTES_MAX) begin
				lk_byte_d = lk_byte_base + BYTES_LATCH;
			end
			if (lk_byte_d == BYTES_LATCH) begin
				lk_op_d = lk_sh_d;
			end
			if (lk_byte_d == BYTES_ADDR_HI) begin
				lk_addr_d[15:8] = lk_sh_d;
				lk_dat_d = lk_sh_d;
			end
			if (lk_byte_d == BYTES_ADDR_LO) begin
				lk_addr_d[7:0] = lk_sh_d;
			end
		end
	end

	// Only the start flag clears on deselect, so the frame stays frozen for the system side
	always_ff @(posedge spi_sck or posedge spi_cs_n) begin
		if (spi_cs_n) begin
			lk_started_q <= 1'b0;
		end else begin
			lk_started_q <= 1'b1;
		end
	end

	always_ff @(posedge spi_sck) begin
		lk_sh_q <= lk_sh_d;
		lk_bit_q <= lk_bit_d;
		lk_byte_q <= lk_byte_d;
		lk_op_q <= lk_op_d;
		lk_addr_q <= lk_addr_d;
		lk_dat_q <= lk_dat_d;
	end

	// Status snapshot into the link domain
	eswp_sync #(.W(8), .RST_VAL(STATUS_RESET)) u_stat_sync (
		.clk(spi_sck),
		.rst(1'b0),
		.d(status_view),
		.q(lk_stat)
	);

	// Link domain: serial output on falling clock
	logic so_d;
	logic so_oe_d;

	always_comb begin
		so_d = 1'b0;
		so_oe_d = 1'b0;
		if (lk_started_q && lk_op_q == OP_STATUS_READ && lk_byte_q != BYTES_ZERO) begin
			so_oe_d = 1'b1;
			so_d = lk_stat[BIT_LAST - lk_bit_q];
		end
	end

	// Deselect forces the output off, which also covers power-up standby
	always_ff @(negedge spi_sck or posedge spi_cs_n) begin
		if (spi_cs_n) begin
			spi_so <= 1'b0;
			spi_so_oe <= 1'b0;
		end else begin
			spi_so <= so_d;
			spi_so_oe <= so_oe_d;
		end
	end

	// System domain: pin synchronisers
	logic cs_hi_s;
	logic wp_n_s;

	eswp_sync #(.W(1), .RST_VAL(1'b1)) u_cs_sync (
		.clk(sys_clk),
		.rst(srst),
		.d(spi_cs_n),
		.q(cs_hi_s)
	);

	eswp_sync #(.W(1), .RST_VAL(1'b1)) u_wp_sync (
		.clk(sys_clk),
		.rst(srst),
		.d(wp_n),
		.q(wp_n_s)
	);

	// Write cycle timer
	logic wr_start;
	logic busy;

	eswp_write_timer #(.CYCLES(WRITE_CYCLES)) u_timer (
		.clk(sys_clk),
		.srst(srst),
		.start(wr_start),
		.busy(busy)
	);

	// System domain: power state, latch, nonvolatile bits
	eswp_pwr_e pwr_q;
	eswp_pwr_e pwr_d;
	logic cs_prev_q;
	logic wel_q;
	logic wel_d;
	logic [2:0] nv_q;
	logic [2:0] nv_d;
	logic commit_d;
	logic go_d;
	logic [12:0] go_addr_d;
	logic [7:0] view_d;
	logic frame_end;
	logic hw_prot;
	logic len_latch;
	logic len_status;
	logic len_array;
	logic cs_prev_d;
	logic access_ok_d;

	assign nv_store = nv_q;

	always_comb begin
		// Frame fields are stable here: the link clock has stopped once select is high
		frame_end = cs_hi_s && !cs_prev_q && pwr_q == PWR_ACTIVE;
		hw_prot = nv_q[NV_HWPEN] && !wp_n_s;
		len_latch = lk_byte_q == BYTES_LATCH && lk_bit_q == BIT_BOUNDARY;
		len_status = lk_byte_q == BYTES_STATUS_WR && lk_bit_q == BIT_BOUNDARY;
		len_array = lk_byte_q >= BYTES_ARRAY_WR_MIN && lk_bit_q == BIT_BOUNDARY;
		pwr_d = pwr_q;
		wel_d = wel_q;
		nv_d = nv_q;
		commit_d = 1'b0;
		go_d = 1'b0;
		go_addr_d = array_wr_addr;
		wr_start = 1'b0;
		cs_prev_d = cs_hi_s;
		access_ok_d = !busy;
		unique case (pwr_q)
			PWR_LOAD: begin
				nv_d = nv_restore;
				pwr_d = PWR_WAIT_HI;
			end
			PWR_WAIT_HI: begin
				if (cs_hi_s) begin
					pwr_d = PWR_WAIT_LO;
				end
			end
			PWR_WAIT_LO: begin
				if (!cs_hi_s) begin
					pwr_d = PWR_ACTIVE;
				end
			end
			PWR_ACTIVE: begin
			end
		endcase
		if (frame_end) begin
			unique case (lk_op_q)
				OP_LATCH_SET: begin
					if (len_latch) begin
						wel_d = 1'b1;
					end
				end
				OP_LATCH_CLEAR: begin
					if (len_latch) begin
						wel_d = 1'b0;
					end
				end
				OP_STATUS_WRITE: begin
					if (len_status && wel_q && !busy && !hw_prot) begin
						nv_d[NV_HWPEN] = lk_dat_q[ST_HWPEN];
						nv_d[NV_BPHI] = lk_dat_q[ST_BPHI];
						nv_d[NV_BPLO] = lk_dat_q[ST_BPLO];
						wel_d = 1'b0;
						commit_d = 1'b1;
						wr_start = 1'b1;
					end
				end
				OP_ARRAY_WRITE: begin
					// Start address decides: a page never straddles a protect boundary
					if (len_array && wel_q && !busy &&
							!eswp_addr_protected(nv_q[1:0], lk_addr_q[12:0])) begin
						go_d = 1'b1;
						go_addr_d = lk_addr_q[12:0];
						wel_d = 1'b0;
						wr_start = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
		view_d = STATUS_RESET;
		view_d[ST_HWPEN] = nv_q[NV_HWPEN];
		view_d[ST_BPHI] = nv_q[NV_BPHI];
		view_d[ST_BPLO] = nv_q[NV_BPLO];
		view_d[ST_WEL] = wel_q;
		view_d[ST_WIP] = busy;
		if (srst) begin
			pwr_d = PWR_LOAD;
			wel_d = 1'b0;
			nv_d = NV_RESET;
			commit_d = 1'b0;
			go_d = 1'b0;
			go_addr_d = '0;
			cs_prev_d = 1'b1;
			access_ok_d = 1'b0;
			view_d = STATUS_RESET;
		end
	end

	always_ff @(posedge sys_clk) begin
		pwr_q <= pwr_d;
		cs_prev_q <= cs_prev_d;
		wel_q <= wel_d;
		nv_q <= nv_d;
		nv_commit <= commit_d;
		array_wr_go <= go_d;
		array_wr_addr <= go_addr_d;
		array_access_ok <= access_ok_d;
		status_view <= view_d;
	end

	// Checks
	busy_view_a: assert property (@(posedge sys_clk) disable iff (srst)
		status_view[ST_WIP] == $past(busy))
		else $error("busy flag does not follow the write cycle");

	latch_set_a: assert property (@(posedge sys_clk) disable iff (srst)
		(frame_end && lk_op_q == OP_LATCH_SET && len_latch) |=> wel_q ##1 status_view[ST_WEL])
		else $error("latch set command did not set the latch");

	wel_after_write_a: assert property (@(posedge sys_clk) disable iff (srst)
		(array_wr_go || nv_commit) |-> !wel_q)
		else $error("latch still set after a write");

	protect_range_a: assert property (@(posedge sys_clk) disable iff (srst)
		array_wr_go |-> !eswp_addr_protected(nv_q[1:0], array_wr_addr))
		else $error("write started inside a protected range");

	hw_block_a: assert property (@(posedge sys_clk) disable iff (srst)
		(frame_end && lk_op_q == OP_STATUS_WRITE && hw_prot) |=> ($stable(nv_q) && !nv_commit))
		else $error("status bits changed under hardware protection");

	busy_ignore_a: assert property (@(posedge sys_clk) disable iff (srst)
		(frame_end && busy) |=> (!array_wr_go && !nv_commit && $stable(nv_q)))
		else $error("write accepted while a cycle was running");

	latch_needed_a: assert property (@(posedge sys_clk) disable iff (srst)
		$rose(busy) |-> $past(wel_q))
		else $error("write started without the latch set");

	powerup_clear_a: assert property (@(posedge sys_clk)
		srst |=> (!wel_q && !array_wr_go && pwr_q == PWR_LOAD))
		else $error("power-up state wrong");

	inactive_a: assert property (@(posedge sys_clk) disable iff (srst)
		(pwr_q != PWR_ACTIVE) |=> ($stable(wel_q) && !array_wr_go))
		else $error("activity before first select fall");

	so_status_a: assert property (@(posedge spi_sck) disable iff (spi_cs_n)
		spi_so_oe |-> lk_op_q == OP_STATUS_READ)
		else $error("output driven outside a status read");
endmodule : eswp_core

// ===== rtl/eswp_pkg.sv
// Shared constants, opcodes and helpers for the status and write-protect block
package eswp_pkg;
	// Timing
	localparam int SYS_CLK_MHZ = 25;
	localparam int WRITE_TIME_US_DEF = 1000;

	// Command opcodes
	localparam logic [7:0] OP_STATUS_READ = 8'h05;
	localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OP_LATCH_SET = 8'h06;
	localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
	localparam logic [7:0] OP_ARRAY_READ = 8'h03;
	localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;

	// Status register layout
	localparam int ST_HWPEN = 7;
	localparam int ST_BPHI = 3;
	localparam int ST_BPLO = 2;
	localparam int ST_WEL = 1;
	localparam int ST_WIP = 0;
	localparam logic [7:0] STATUS_RESET = 8'h00;

	// Nonvolatile triple layout
	localparam int NV_HWPEN = 2;
	localparam int NV_BPHI = 1;
	localparam int NV_BPLO = 0;
	localparam logic [2:0] NV_RESET = 3'h0;

	// Frame lengths in whole bytes, and bit positions within a byte
	localparam logic [5:0] BYTES_ZERO = 6'h00;
	localparam logic [5:0] BYTES_LATCH = 6'h01;
	localparam logic [5:0] BYTES_STATUS_WR = 6'h02;
	localparam logic [5:0] BYTES_ADDR_HI = 6'h02;
	localparam logic [5:0] BYTES_ADDR_LO = 6'h03;
	localparam logic [5:0] BYTES_ARRAY_WR_MIN = 6'h04;
	localparam logic [5:0] BYTES_MAX = 6'h3F;
	localparam logic [2:0] BIT_BOUNDARY = 3'h0;
	localparam logic [2:0] BIT_FIRST = 3'h1;
	localparam logic [2:0] BIT_LAST = 3'h7;

	// Block-protect codes and range bounds
	localparam logic [1:0] BP_NONE = 2'h0;
	localparam logic [1:0] BP_QUARTER = 2'h1;
	localparam logic [1:0] BP_HALF = 2'h2;
	localparam logic [12:0] ADDR_QUARTER = 13'h1800;
	localparam logic [12:0] ADDR_HALF = 13'h1000;

	typedef enum logic [1:0] {PWR_LOAD, PWR_WAIT_HI, PWR_WAIT_LO, PWR_ACTIVE} eswp_pwr_e;

	function automatic logic eswp_addr_protected(input logic [1:0] bp, input logic [12:0] addr);
		unique case (bp)
			BP_NONE: eswp_addr_protected = 1'b0;
			BP_QUARTER: eswp_addr_protected = (addr >= ADDR_QUARTER);
			BP_HALF: eswp_addr_protected = (addr >= ADDR_HALF);
			default: eswp_addr_protected = 1'b1;
		endcase
	endfunction : eswp_addr_protected
endpackage : eswp_pkg

// ===== rtl/eswp_sync.sv
// Two-flop level synchroniser
`timescale 1ns/1ns
module eswp_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] q_d;

	always_comb begin
		meta_d = rst ? RST_VAL : d;
		q_d = rst ? RST_VAL : meta_q;
	end

	always_ff @(posedge clk) begin
		meta_q <= meta_d;
		q <= q_d;
	end
endmodule : eswp_sync

// ===== rtl/eswp_write_timer.sv
// Self-timed write cycle counter
`timescale 1ns/1ns
module eswp_write_timer #(
	parameter int CYCLES = 25000
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Control
	input wire logic start,
	output logic busy
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] CNT_ONE = CW'(1);
	localparam logic [CW-1:0] CNT_LOAD = CW'(CYCLES);

	generate
		if (CYCLES < 1) begin : g_bad
			$error("write timer needs at least one cycle");
		end
	endgenerate

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic busy_d;

	always_comb begin
		cnt_d = cnt_q;
		busy_d = busy;
		if (start && !busy) begin
			cnt_d = CNT_LOAD;
			busy_d = 1'b1;
		end else if (busy) begin
			cnt_d = cnt_q - CNT_ONE;
			busy_d = (cnt_q != CNT_ONE);
		end
		if (srst) begin
			cnt_d = '0;
			busy_d = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		cnt_q <= cnt_d;
		busy <= busy_d;
	end
endmodule : eswp_write_timer

// ===== verif/eswp_host.sv
// SPI host controller model that drives the serial link of the block
`timescale 1ns/1ns
module eswp_host (
	// Serial link
	output logic sck,
	output logic cs_n,
	output logic si,
	input wire logic so
);
	initial begin
		sck = 1'h0;
		cs_n = 1'h1;
		si = 1'h0;
	end

	// Clock only runs inside frames; deselect comes right after the last whole bit
	task automatic xfer(input logic [31:0] data, input int nbits, output logic [31:0] rx);
		rx = '0;
		cs_n = 1'h0;
		for (int i = nbits - 1; i >= 0; i--) begin
			si = data[i];
			#6 sck = 1'h1;
			rx = {rx[30:0], so};
			#6 sck = 1'h0;
		end
		#6 cs_n = 1'h1;
		// Released line must not keep showing the last bit
		si = ~si;
		#200;
	endtask : xfer
endmodule : eswp_host

// ===== verif/test_eeprom_status_write_protect.sv
// Self-checking bench for the status and write-protect block
`timescale 1ns/1ns
module test_eeprom_status_write_protect;
	import eswp_pkg::*;
	typedef struct {logic [31:0] data; int nbits; logic wp; logic [7:0] st; int go; int nv;} eswp_row_s;
	logic sys_clk = 1'h0;
	logic srst = 1'h1;
	logic wp_n = 1'h1;
	logic spi_sck, spi_cs_n, spi_si, spi_so, spi_so_oe;
	logic [2:0] nv_mem = 3'h0;
	logic [2:0] nv_store;
	logic nv_commit, array_wr_go, array_access_ok;
	logic [12:0] array_wr_addr;
	logic [7:0] status_view;
	logic [31:0] rx;
	int fail_count = 0;
	int n_checks = 0;
	int go_cnt = 0;
	int nv_cnt = 0;
	eswp_row_s rows[18];

	always #20 sys_clk = ~sys_clk;

	eswp_core #(.WRITE_TIME_US(2)) DUT (.sys_clk, .srst, .spi_sck, .spi_cs_n, .spi_si, .spi_so, .spi_so_oe, .wp_n,
		.nv_restore(nv_mem), .nv_store, .nv_commit, .array_wr_go, .array_wr_addr, .array_access_ok, .status_view);

	// Undriven data line shows the inverse of the last bit, so a dropped enable corrupts reads
	eswp_host host (.sck(spi_sck), .cs_n(spi_cs_n), .si(spi_si), .so(spi_so_oe ? spi_so : ~spi_so));

	// Stands in for the nonvolatile cells so restored bits survive a reset
	always @(posedge sys_clk) begin
		if (nv_commit === 1'h1) begin
			nv_mem <= nv_store;
			nv_cnt++;
		end
		if (array_wr_go === 1'h1)
			go_cnt++;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic close_out;
		$display("checks=%0d mismatches=%0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out

	task automatic spi(input logic [31:0] d, input int n);
		@(posedge sys_clk);
		#1;
		host.xfer(d, n, rx);
	endtask : spi

	task automatic read_status(input logic [7:0] exp);
		spi(32'h0000_0500, 16);
		check(rx[7:0], exp);
		check(status_view, exp);
	endtask : read_status

	initial begin
		#300000;
		fail_count++;
		close_out();
	end

	initial begin
		rows = '{
			'{32'h06, 8, 1'h1, 8'h02, 0, 0}, '{32'h04, 8, 1'h1, 8'h00, 0, 0},
			'{32'h018C, 16, 1'h1, 8'h00, 0, 0}, '{32'h06, 8, 1'h1, 8'h02, 0, 0},
			'{32'h01FF, 16, 1'h1, 8'h8C, 0, 1}, '{32'h06, 8, 1'h0, 8'h8E, 0, 1},
			'{32'h0100, 16, 1'h0, 8'h8E, 0, 1}, '{32'h020000AA, 32, 1'h0, 8'h8E, 0, 1},
			'{32'h0104, 16, 1'h1, 8'h04, 0, 2}, '{32'h06, 8, 1'h1, 8'h06, 0, 2},
			'{32'h02180055, 32, 1'h1, 8'h06, 0, 2}, '{32'h0217FF55, 32, 1'h0, 8'h04, 1, 2},
			'{32'h06, 8, 1'h1, 8'h06, 1, 2}, '{32'h010000, 24, 1'h1, 8'h06, 1, 2},
			'{32'h0188, 16, 1'h1, 8'h88, 1, 3}, '{32'h06, 8, 1'h0, 8'h8A, 1, 3},
			'{32'h02100011, 32, 1'h0, 8'h8A, 1, 3}, '{32'h020FFF11, 32, 1'h0, 8'h88, 2, 3}
		};
		repeat (5) @(posedge sys_clk);
		#1 srst = 1'h0;
		repeat (10) @(posedge sys_clk);
		foreach (rows[i]) begin
			@(posedge sys_clk);
			#1 wp_n = rows[i].wp;
			spi(rows[i].data, rows[i].nbits);
			#2400;
			read_status(rows[i].st);
			check(go_cnt, rows[i].go);
			check(nv_cnt, rows[i].nv);
		end
		check(array_wr_addr, 13'h0FFF);
		// Second write and status read land inside the running write cycle
		spi(32'h06, 8);
		spi(32'h02000033, 32);
		spi(32'h06, 8);
		spi(32'h02050044, 32);
		read_status(8'h8B);
		check(array_access_ok, 1'h0);
		check(go_cnt, 3);
		check(array_wr_addr, 13'h0000);
		#2400;
		read_status(8'h8A);
		check(array_access_ok, 1'h1);
		@(posedge sys_clk);
		#1 srst = 1'h1;
		repeat (5) @(posedge sys_clk);
		#1;
		check(spi_so_oe, 1'h0);
		check(status_view, 8'h00);
		check(array_access_ok, 1'h0);
		srst = 1'h0;
		repeat (10) @(posedge sys_clk);
		read_status(8'h88);
		check(nv_store, 3'h6);
		close_out();
	end
endmodule : test_eeprom_status_write_protect
